// ---- verilog/gpib_controller.sv ----
/*
  Bus controller that addresses and exchanges bytes with one peripheral
  interface over the open-drain instrument bus (talker and listener ends).
  Assumes bus inputs synchronous to ref_clk and a wire level resolved
  outside from the output enables; low level means asserted.
*/
module gpib_controller
  import gpib_host_pkg::*;
#(
  parameter int HOLD_CYCLES   = gpib_host_pkg::HOLD_CYC,
  parameter int ACCEPT_CYCLES = gpib_host_pkg::ACCEPT_CYC
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               srst,
  // Command port
  input  wire logic               cmd_valid,
  input  wire gpib_host_pkg::cmd_t cmd,
  output logic                    cmd_ready,
  output logic                    cmd_done,
  output logic                    no_listener,
  // Received bytes
  output logic                    rx_valid,
  output logic [7:0]              rx_data,
  input  wire logic               rx_ready,
  // Bus pins
  input  wire gpib_host_pkg::bus_in_t  bus_in,
  output gpib_host_pkg::bus_out_t      bus_out
);

  import gpib_host_pkg::*;

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST   = CNT_W'(HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] ACCEPT_LAST = CNT_W'(ACCEPT_CYCLES - 1);

  // ****************************************
  // State
  // ****************************************
  state_t           state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  bus_out_t         pins_r, pins_nxt;
  logic             sess_r, sess_nxt;
  logic             ready_r, ready_nxt;
  logic             done_r, done_nxt;
  logic             err_r, err_nxt;
  logic             push_r, push_nxt;
  logic [7:0]       byte_r, byte_nxt;
  logic             buf_ready;

  assign cmd_ready   = ready_r;
  assign cmd_done    = done_r;
  assign no_listener = err_r;
  assign bus_out     = pins_r;

  // Next state of the handshake sequencer
  always_comb begin
    state_nxt         = state_r;
    cnt_nxt           = cnt_r;
    pins_nxt          = pins_r;
    sess_nxt          = sess_r;
    done_nxt          = 1'b0;
    err_nxt           = 1'b0;
    push_nxt          = 1'b0;
    byte_nxt          = byte_r;
    pins_nxt.atn_out  = 1'b0;
    pins_nxt.dav_out  = 1'b0;
    pins_nxt.nrfd_out = 1'b0;
    pins_nxt.ndac_out = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (cmd_valid && ready_r) begin
          cnt_nxt = CNT_ZERO;
          case (cmd.op)
            OP_CMD, OP_DATA: begin
              // Talker role: our listener drivers off, byte on the lines
              pins_nxt.atn_oe  = (cmd.op == OP_CMD);
              pins_nxt.nrfd_oe = 1'b0;
              pins_nxt.ndac_oe = 1'b0;
              pins_nxt.dio_out = ~cmd.data;
              pins_nxt.dio_oe  = DIO_ALL_ON;
              sess_nxt         = 1'b0;
              state_nxt        = S_T_SETTLE;
            end
            default: begin
              pins_nxt.atn_oe = 1'b0;
              if (sess_r) begin
                state_nxt = S_L_READY;
              end else begin
                pins_nxt.nrfd_oe = 1'b1;
                pins_nxt.ndac_oe = 1'b1;
                sess_nxt         = 1'b1;
                state_nxt        = S_L_HOLD;
              end
            end
          endcase
        end
      end
      S_T_SETTLE: begin
        cnt_nxt = cnt_r + CNT_ONE;
        if (bus_in.nrfd && bus_in.ndac && cnt_r == SETTLE_LAST) begin
          // Nobody listening: abandon the byte
          pins_nxt.dio_oe = DIO_ALL_OFF;
          err_nxt         = 1'b1;
          done_nxt        = 1'b1;
          state_nxt       = S_IDLE;
        end else if (cnt_r == SETTLE_LAST) begin
          state_nxt = S_T_WAIT_NRFD;
        end
      end
      S_T_WAIT_NRFD: begin
        if (bus_in.nrfd) begin
          pins_nxt.dav_oe = 1'b1;
          state_nxt       = S_T_WAIT_NDAC;
        end
      end
      S_T_WAIT_NDAC: begin
        if (bus_in.ndac) begin
          pins_nxt.dav_oe = 1'b0;
          pins_nxt.dio_oe = DIO_ALL_OFF;
          done_nxt        = 1'b1;
          state_nxt       = S_IDLE;
        end
      end
      S_L_HOLD: begin
        if (cnt_r != HOLD_LAST) begin
          cnt_nxt = cnt_r + CNT_ONE;
        end else if (buf_ready) begin
          pins_nxt.nrfd_oe = 1'b0;
          state_nxt        = S_L_READY;
        end
      end
      S_L_READY: begin
        if (pins_r.nrfd_oe) begin
          // Ready only when the buffer can take a byte
          if (buf_ready) begin
            pins_nxt.nrfd_oe = 1'b0;
          end
        end else if (!bus_in.dav) begin
          pins_nxt.nrfd_oe = 1'b1;
          byte_nxt         = ~bus_in.dio;
          push_nxt         = 1'b1;
          cnt_nxt          = CNT_ZERO;
          state_nxt        = S_L_CAPTURE;
        end
      end
      S_L_CAPTURE: begin
        cnt_nxt = cnt_r + CNT_ONE;
        if (cnt_r == ACCEPT_LAST) begin
          pins_nxt.ndac_oe = 1'b0;
          state_nxt        = S_L_WAIT_DAV;
        end
      end
      S_L_WAIT_DAV: begin
        if (bus_in.dav) begin
          pins_nxt.ndac_oe = 1'b1;
          done_nxt         = 1'b1;
          state_nxt        = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    ready_nxt = (state_nxt == S_IDLE);
  end

  // Register sequencer state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= S_IDLE;
      cnt_r   <= CNT_ZERO;
      pins_r  <= '0;
      sess_r  <= 1'b0;
      ready_r <= 1'b0;
      done_r  <= 1'b0;
      err_r   <= 1'b0;
      push_r  <= 1'b0;
      byte_r  <= BYTE_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      pins_r  <= pins_nxt;
      sess_r  <= sess_nxt;
      ready_r <= ready_nxt;
      done_r  <= done_nxt;
      err_r   <= err_nxt;
      push_r  <= push_nxt;
      byte_r  <= byte_nxt;
    end
  end

  // ****************************************
  // Receive buffer
  // ****************************************
  rx_buffer #(
    .WIDTH (8),
    .DEPTH (2)
  ) u_rx_buffer (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .in_valid  (push_r),
    .in_data   (byte_r),
    .in_ready  (buf_ready),
    .out_valid (rx_valid),
    .out_data  (rx_data),
    .out_ready (rx_ready)
  );

  // ****************************************
  // Checks
  // ****************************************
  logic [CNT_W-1:0] low_cnt_r;
  logic [CNT_W-1:0] acc_cnt_r;

  // Cycles spent in hold and in capture
  always_ff @(posedge ref_clk) begin
    if (srst || state_r == S_IDLE) begin
      low_cnt_r <= CNT_ZERO;
      acc_cnt_r <= CNT_ZERO;
    end else begin
      if (state_r == S_L_HOLD) begin
        low_cnt_r <= low_cnt_r + CNT_ONE;
      end
      if (state_r == S_L_CAPTURE) begin
        acc_cnt_r <= acc_cnt_r + CNT_ONE;
      end
    end
  end

  hold_time_a: assert property (@(posedge ref_clk) disable iff (srst)
    (state_r == S_L_HOLD && state_nxt == S_L_READY) |-> low_cnt_r >= HOLD_LAST)
    else $error("NRFD released before hold time");

  accept_time_a: assert property (@(posedge ref_clk) disable iff (srst)
    ($fell(pins_r.ndac_oe) && state_r == S_L_WAIT_DAV) |-> $past(acc_cnt_r) >= ACCEPT_LAST && pins_r.nrfd_oe)
    else $error("NDAC released too early or with NRFD free");

  dav_release_a: assert property (@(posedge ref_clk) disable iff (srst)
    (state_r == S_T_WAIT_NDAC && bus_in.ndac) |=> !pins_r.dav_oe && pins_r.dio_oe == DIO_ALL_OFF)
    else $error("DAV not released after NDAC high");

  dav_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(pins_r.dav_oe) |-> $past(bus_in.nrfd) && $past(state_r) == S_T_WAIT_NRFD)
    else $error("DAV asserted without NRFD high");

  busy_stall_a: assert property (@(posedge ref_clk) disable iff (srst)
    (state_r == S_T_WAIT_NRFD && !bus_in.nrfd) |=> !pins_r.dav_oe && state_r == S_T_WAIT_NRFD)
    else $error("Handshake moved while NRFD held low");

  settle_a: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(pins_r.dio_oe[0]) |-> !pins_r.dav_oe [*8])
    else $error("DAV driven during data settle");

  capture_a: assert property (@(posedge ref_clk) disable iff (srst)
    (state_r == S_L_READY && !pins_r.nrfd_oe && !bus_in.dav) |=> push_r && pins_r.nrfd_oe
      ##1 pins_r.ndac_oe)
    else $error("Byte not captured on DAV low");

  ready_order_a: assert property (@(posedge ref_clk) disable iff (srst)
    ($fell(pins_r.nrfd_oe) && state_r == S_L_READY) |-> pins_r.ndac_oe && !pins_r.atn_oe)
    else $error("NRFD released without NDAC held");

endmodule : gpib_controller

// ---- verilog/gpib_host_pkg.sv ----
/*
  Shared types and constants for the instrument bus controller:
  command carrier, bus pin groups, state list and handshake timing.
  Assumes a single 250 MHz clock and bus pins that are open-drain.
*/
package gpib_host_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ   = 250;
  localparam int SETTLE_US = 2;    // Data settle before DAV
  localparam int HOLD_US   = 38;   // NRFD and NDAC hold after ATN release
  localparam int ACCEPT_US = 21;   // Least capture time before NDAC release
  localparam int CNT_W     = 16;

  // Least time in whole clock cycles, never under one
  function automatic int us_to_cycles(input int us);
    int c;
    c = us * CLK_MHZ;
    return (c < 1) ? 1 : c;
  endfunction : us_to_cycles

  localparam int               SETTLE_CYC  = us_to_cycles(SETTLE_US);
  localparam int               HOLD_CYC    = us_to_cycles(HOLD_US);
  localparam int               ACCEPT_CYC  = us_to_cycles(ACCEPT_US);
  localparam logic [CNT_W-1:0] CNT_ZERO    = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;
  localparam logic [7:0]       BYTE_ZERO   = 8'h00;
  localparam logic [7:0]       DIO_ALL_ON  = 8'hFF;
  localparam logic [7:0]       DIO_ALL_OFF = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    OP_CMD,     // Byte sent with ATN low
    OP_DATA,    // Byte sent with ATN high, device listening
    OP_READ     // One byte taken from a talking device
  } op_t;

  typedef struct packed {
    op_t        op;
    logic [7:0] data;
  } cmd_t;

  typedef struct packed {
    logic       atn;
    logic       dav;
    logic       nrfd;
    logic       ndac;
    logic [7:0] dio;
  } bus_in_t;

  typedef struct packed {
    logic       atn_out;
    logic       atn_oe;
    logic       dav_out;
    logic       dav_oe;
    logic       nrfd_out;
    logic       nrfd_oe;
    logic       ndac_out;
    logic       ndac_oe;
    logic [7:0] dio_out;
    logic [7:0] dio_oe;
  } bus_out_t;

  typedef enum logic [3:0] {
    S_IDLE,
    S_T_SETTLE,
    S_T_WAIT_NRFD,
    S_T_WAIT_NDAC,
    S_L_HOLD,
    S_L_READY,
    S_L_CAPTURE,
    S_L_WAIT_DAV
  } state_t;

endpackage : gpib_host_pkg

// ---- verilog/rx_buffer.sv ----
/*
  Small shift FIFO for received bytes; head entry sits in flip-flops.
  Assumes the writer checks in_ready before every push.
*/
module rx_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;

  // Full when the last slot holds a word
  assign in_ready  = !vld_r[DEPTH-1];
  assign out_valid = vld_r[0];
  assign out_data  = mem_r[0];

  // Shift down on pop, write into first free slot on push
  always_comb begin
    logic pop;
    logic placed;
    pop    = vld_r[0] && out_ready;
    placed = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && i < DEPTH - 1) begin
        mem_nxt[i] = mem_r[i+1];
        vld_nxt[i] = vld_r[i+1];
      end else if (pop) begin
        mem_nxt[i] = mem_r[i];
        vld_nxt[i] = 1'b0;
      end else begin
        mem_nxt[i] = mem_r[i];
        vld_nxt[i] = vld_r[i];
      end
    end
    for (int i = 0; i < DEPTH; i++) begin
      if (in_valid && in_ready && !placed && !vld_nxt[i]) begin
        mem_nxt[i] = in_data;
        vld_nxt[i] = 1'b1;
        placed     = 1'b1;
      end
    end
  end

  // Register storage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      vld_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      vld_r <= vld_nxt;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

endmodule : rx_buffer

// ---- testbench/periph_model.sv ----
/*
  Behavioural peripheral interface on the instrument bus: acceptor,
  source handshake and address memory in one model.
  Assumes resolved wire levels in (1 = high) and pull-low drives out.
*/
module periph_model #(
  parameter logic [4:0] DEV    = 5'h02, // Arbitrary device number
  parameter int         SETTLE = 4
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Resolved bus levels
  input  wire logic       atn,
  input  wire logic       dav,
  input  wire logic       nrfd,
  input  wire logic       ndac,
  input  wire logic [7:0] dio,
  // Peripheral side
  input  wire logic       busy_hold,
  input  wire logic [3:0] ack_delay,
  input  wire logic [7:0] tx_byte,
  output logic            listen_selected,
  output logic            talker_selected,
  output logic            got_byte,
  output logic [7:0]      got_data,
  output logic            byte_taken,
  // Pull-low drives
  output logic            pull_dav,
  output logic            pull_nrfd,
  output logic            pull_ndac,
  output logic [7:0]      pull_dio
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       tlk_r, dav_q, nrfd_q, ndac_q, in_r, nrfd_r, ndac_r, latch_r, sreq_r, acc_on;
  logic [3:0] ack_r;
  int         scnt_r;

  assign talker_selected = tlk_r & atn;
  assign acc_on          = !atn || (listen_selected && !talker_selected);
  // DAV only from a set latch
  assign pull_dav        = talker_selected & latch_r & sreq_r;
  assign pull_dio        = talker_selected ? tx_byte : 8'h00;
  assign pull_nrfd       = acc_on & nrfd_r;
  assign pull_ndac       = acc_on & ndac_r;

  // Acceptor, decoder and source latch
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      {listen_selected, tlk_r, in_r, nrfd_r, ndac_r, latch_r, sreq_r} <= '0;
      {dav_q, nrfd_q, ndac_q} <= 3'h7;
      {got_byte, byte_taken, ack_r, got_data} <= '0;
      scnt_r <= SETTLE;
    end else begin
      dav_q <= dav;
      nrfd_q <= nrfd;
      ndac_q <= ndac;
      got_byte <= 1'b0;
      byte_taken <= 1'b0;
      if (!acc_on) begin
        {in_r, nrfd_r, ndac_r} <= '0;
      end else if (dav_q && !dav) begin
        // NRFD low and strobe on DAV fall
        in_r <= 1'b1;
        nrfd_r <= 1'b1;
        ack_r <= ack_delay;
        if (atn) begin
          got_byte <= 1'b1;
          got_data <= ~dio;
        end else if (~dio == {3'b001, DEV}) listen_selected <= 1'b1;
        else if (~dio == 8'h3F) listen_selected <= 1'b0;
        else if (~dio == {3'b010, DEV}) tlk_r <= 1'b1;
        else if (~dio == 8'h5F) tlk_r <= 1'b0;
      end else if (in_r) begin
        // NDAC freed once the ack_delay count runs out, rearm on DAV rise
        if (!dav_q && dav) begin
          in_r <= 1'b0;
          ndac_r <= 1'b1;
        end else if (ack_r != 4'h0) ack_r <= ack_r - 4'h1;
        else ndac_r <= 1'b0;
      end else begin
        // NDAC low first, NRFD held while busy
        ndac_r <= 1'b1;
        nrfd_r <= busy_hold | !ndac_r;
      end
      if (!talker_selected) begin
        {latch_r, sreq_r} <= '0;
        scnt_r <= SETTLE;
      end else if (ndac && !ndac_q && latch_r) begin
        {latch_r, sreq_r} <= '0;
        scnt_r <= SETTLE;
        byte_taken <= 1'b1;
      end else begin
        if (nrfd && !nrfd_q) latch_r <= 1'b1;
        if (scnt_r != 0) scnt_r <= scnt_r - 1;
        else sreq_r <= 1'b1;
      end
    end
  end
endmodule : periph_model

// ---- testbench/gpib_controller_tb.sv ----
/*
  Self-checking bench for the bus controller against a peripheral model.
  Assumes open-drain lines resolved here from all pull-low drives.
*/
module gpib_controller_tb import gpib_host_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         HOLD_C = 20;
  localparam int         ACC_C  = 10;
  localparam logic [4:0] DEV    = 5'h02;
  logic        ref_clk = 0, srst = 1, cmd_valid = 0, rx_ready = 0, busy_hold = 0, drain_en = 0;
  cmd_t        cmd = '{OP_CMD, 8'h00};
  logic        cmd_ready, cmd_done, no_listener, rx_valid, m_dav, m_nrfd, m_ndac;
  logic        lsn, tlk, got_byte, byte_taken, dav_p = 1, nrfd_p = 1, ndac_p = 1, hold_armed = 0;
  logic [7:0]  rx_data, m_dio, got_data, tx_byte = 0;
  logic [3:0]  ack_delay = 0;
  logic [31:0] lfsr_r = 32'h285874F4;
  bus_in_t     bus_in;
  bus_out_t    bus_out;
  int          failures = 0, checks_done = 0, nrfd_low_n = 0, dav_low_n = 0, dav_ndac_n = 0;
  logic [7:0]  exp_dat[$], exp_rd[$] = '{8'h00};

  // Wire levels from every pull-low drive
  assign bus_in = {~bus_out.atn_oe, ~(bus_out.dav_oe | m_dav), ~(bus_out.nrfd_oe | m_nrfd),
                   ~(bus_out.ndac_oe | m_ndac), ~((bus_out.dio_oe & ~bus_out.dio_out) | m_dio)};
  always #2 ref_clk = ~ref_clk;

  gpib_controller #(.HOLD_CYCLES(HOLD_C), .ACCEPT_CYCLES(ACC_C)) u_gpib_controller (
    .ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .no_listener(no_listener), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .bus_in(bus_in), .bus_out(bus_out));
  periph_model #(.DEV(DEV), .SETTLE(4)) u_periph_model (
    .ref_clk(ref_clk), .srst(srst), .atn(bus_in.atn), .dav(bus_in.dav), .nrfd(bus_in.nrfd),
    .ndac(bus_in.ndac), .dio(bus_in.dio), .busy_hold(busy_hold), .ack_delay(ack_delay),
    .tx_byte(tx_byte), .listen_selected(lsn), .talker_selected(tlk), .got_byte(got_byte),
    .got_data(got_data), .byte_taken(byte_taken), .pull_dav(m_dav), .pull_nrfd(m_nrfd),
    .pull_ndac(m_ndac), .pull_dio(m_dio));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic send(input op_t op, input logic [7:0] d);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd = {op, d};
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask : send

  task automatic wait_done(input int lim, output logic got, output logic nl);
    got = 1'b0;
    nl = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(negedge ref_clk);
      got = (cmd_done === 1'b1);
      nl = (no_listener === 1'b1);
    end
  endtask : wait_done

  task automatic run(input op_t op, input logic [7:0] d, input logic nl_exp);
    logic g, nl;
    send(op, d);
    wait_done(3000, g, nl);
    chk("cmd_done", 1, g);
    chk("no_listener", nl_exp, nl);
  endtask : run

  // Random stalls, peripheral bytes, received byte and wire monitors
  always @(negedge ref_clk) begin
    lfsr_r = lfsr_next(lfsr_r);
    busy_hold = (lfsr_r[3:0] == 4'h0);
    ack_delay = lfsr_r[7:4];
    rx_ready = drain_en & lfsr_r[8];
    if (byte_taken === 1'b1) begin
      tx_byte = lfsr_r[15:8];
      exp_rd.push_back(tx_byte);
    end
    if (rx_valid === 1'b1 && rx_ready) chk("rx_data", exp_rd.pop_front(), rx_data);
    if (got_byte === 1'b1) chk("got_data", exp_dat.pop_front(), got_data);
    if (dav_p && !bus_in.dav) chk("nrfd at dav fall", 1, nrfd_p);
    if (tlk === 1'b1 && hold_armed && bus_in.nrfd && !nrfd_p) chk("nrfd hold", 1, nrfd_low_n >= HOLD_C - 1);
    // First NRFD rise after an ATN phase only
    hold_armed = !bus_in.atn || (hold_armed && !(bus_in.nrfd && !nrfd_p));
    if (tlk === 1'b1 && bus_in.ndac && !ndac_p && !bus_in.dav) chk("accept", 1, dav_low_n >= ACC_C - 1);
    if (!bus_in.atn) chk("talker under atn", 0, tlk);
    dav_ndac_n = (!bus_in.dav && bus_in.ndac) ? dav_ndac_n + 1 : 0;
    if (dav_ndac_n == 3) chk("dav after ndac", 0, 1);
    nrfd_low_n = (bus_in.atn && !bus_in.nrfd) ? nrfd_low_n + 1 : 0;
    dav_low_n = !bus_in.dav ? dav_low_n + 1 : 0;
    dav_p = bus_in.dav;
    nrfd_p = bus_in.nrfd;
    ndac_p = bus_in.ndac;
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    logic g, nl;
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("cmd_ready", 1, cmd_ready);
    chk("bus drive", 0, {bus_out.atn_oe, bus_out.dav_oe, bus_out.nrfd_oe, bus_out.ndac_oe, bus_out.dio_oe});
    chk("listen", 0, lsn);
    run(OP_DATA, 8'h55, 1'b1);
    run(OP_CMD, {3'b001, DEV}, 1'b0);
    chk("listen", 1, lsn);
    for (int i = 0; i < 6; i++) begin
      exp_dat.push_back(i == 0 ? {3'b010, DEV} : lfsr_r[23:16]);
      run(OP_DATA, exp_dat[$], 1'b0);
    end
    chk("talker", 0, tlk);
    run(OP_CMD, 8'h3F, 1'b0);
    chk("listen", 0, lsn);
    run(OP_CMD, {3'b010, DEV}, 1'b0);
    run(OP_READ, 8'h00, 1'b0);
    chk("talker", 1, tlk);
    run(OP_READ, 8'h00, 1'b0);
    send(OP_READ, 8'h00);
    wait_done(400, g, nl);
    chk("stall while full", 0, g);
    drain_en = 1'b1;
    wait_done(3000, g, nl);
    chk("done after drain", 1, g);
    run(OP_READ, 8'h00, 1'b0);
    run(OP_CMD, 8'h5F, 1'b0);
    run(OP_DATA, 8'hA5, 1'b1);
    repeat (100) @(negedge ref_clk);
    chk("data left", 0, exp_dat.size());
    chk("reads left", 1, exp_rd.size());
    tally_and_finish();
  end
endmodule : gpib_controller_tb
